// ===== core/tasl_pkg.sv
// Constants shared by the temperature alarm and status logic
package tasl_pkg;
   // Command pointer values
   localparam logic [7:0] REG_LOCAL = 8'h07;
   localparam logic [7:0] REG_EXT = 8'h09;
   localparam logic [7:0] REG_MFG = 8'h0a;
   localparam logic [7:0] REG_CFG1 = 8'h41;
   localparam logic [7:0] REG_CFG2 = 8'h42;
   localparam logic [7:0] REG_CFG3 = 8'h43;
   localparam logic [7:0] REG_STAT1 = 8'h44;
   localparam logic [7:0] REG_STAT2 = 8'h45;
   localparam logic [7:0] REG_STAT3 = 8'h46;
   localparam logic [3:0] BANK_TEMP = 4'h0;
   localparam logic [3:0] BANK_ALIM = 4'h1;
   localparam logic [3:0] BANK_OLIM = 4'h2;
   // Reset values
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   // Limits indexed by channel, channel 0 is the local sensor
   localparam logic [6:0][7:0] ALIM_RST = {8'h64, 8'h64, 8'h64, 8'h64, 8'h7f, 8'h6e, 8'h5a};
   localparam logic [6:0][7:0] OLIM_RST = {8'h5a, 8'h5a, 8'h5a, 8'h00, 8'h00, 8'h6e, 8'h00};
   localparam logic [6:0] OT_CH = 7'b1110010;
   // Configuration 1 fields
   localparam int CFG1_STOP = 7;
   localparam int CFG1_SOFT = 6;
   localparam int CFG1_TMO = 5;
   localparam int CFG1_FAST = 4;
   localparam int CFG1_RCAN = 3;
   localparam logic [7:0] CFG1_WMASK = 8'hb8;
   localparam logic [7:0] CFG2_WMASK = 8'h7f;
   localparam logic [7:0] CFG3_WMASK = 8'h39;
   // Data formats
   localparam logic [7:0] FAULT_TEMP = 8'hff;
   localparam logic [8:0] OT_HYST = 9'h004;
   localparam logic [6:0] ARA_ADDR = 7'h0c;
   // Diode fault decision time
   localparam int FAULT_TIME_US = 4000;
   localparam int REF_CLK_MHZ = 10;
   localparam int FAULT_CYC = FAULT_TIME_US * REF_CLK_MHZ;
   typedef enum logic [1:0] {EV_PTR, EV_WR, EV_RD, EV_ARA} tasl_ev_e;
   typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_ACK, LK_RX, LK_TX, LK_HACK} tasl_lk_e;
endpackage

// ===== core/tasl_top.sv
// Alarm, fault and status logic with its 2-wire slave
`timescale 1ns/1ns
// How it works
// R1 - Channel 1 fraction in low byte bits 7:5
// R2 - Open diode sets fault flag, reading FFh
// R3 - Open diode never drives alert or overtemp
// R4 - Fault declared after about 4 ms open
// R5 - After fault, move to next channel
// R6 - Seven alert and four overtemp limits, writable
// R7 - Reading above alert limit raises alert
// R8 - Alert clears on status read or response
// R9 - Alert never stops the conversion sequence
// R10 - Host broadcasts read to alert response address
// R11 - Answer response with own address, arbitrating
// R12 - Lost arbitration: release, keep alert asserted
// R13 - Overtemp above limit, release below limit-4
// R14 - Eight-bit command pointer, resets to zero
// R15 - Control bit 7 stops conversions, standby
// R16 - Control bit 6 restores power-on state
// R17 - Control bit 5 disables bus timeout
// R18 - Bit 4 fast channel 1, bit 3 cancellation
// R19 - Alert mask bits 6:0, local and remotes
// R20 - Overtemp mask bits 5,4,3,0
// R21 - Three status registers: alert, overtemp, fault
// R22 - Alert flags clear on read, re-set later
// R23 - Channel 1 eleven bits, others eight
// R24 - Masked channels flag but drive no output
module tasl_top #(
   parameter logic [6:0] SLAVE_ADDR = 7'h2a,
   // Arbitrary identification value
   parameter logic [7:0] MFG_ID = 8'h5e,
   parameter int FAULT_CYC = tasl_pkg::FAULT_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Serial link
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Conversion front end
   input wire logic conv_done,
   input wire logic [10:0] conv_data,
   input wire logic diode_open,
   output logic [2:0] conv_chan,
   output logic conv_req,
   // Pins and controls
   input wire logic hw_standby_pin,
   output logic alert_oe,
   output logic overtemp_out,
   output logic timeout_dis,
   output logic fast_ch1,
   output logic res_cancel
);
   typedef struct packed {
      logic [7:0] ptr;
      logic [7:0] cfg1;
      logic [7:0] cfg2;
      logic [7:0] cfg3;
      logic [6:0][7:0] temp;
      logic [7:0] ext;
      logic [6:0][7:0] alim;
      logic [6:0][7:0] olim;
      logic [6:0] st1;
      logic [6:0] st2;
      logic [6:0] st3;
      logic [6:0] ot;
      logic alert;
      logic ot_oe;
      logic [2:0] chan;
      logic [2:0] rr;
      logic req;
      logic [15:0] fcnt;
      logic ev_s1;
      logic ev_s2;
      logic ev_s3;
      logic open_s1;
      logic open_s2;
      logic hw_standby_pin_s1;
      logic hw_standby_pin_s2;
      logic [7:0] pub_byte;
      logic pub_tog;
   } tasl_ref_s;

   typedef struct packed {
      logic st_seen;
      tasl_pkg::tasl_lk_e state;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic first;
      logic rw;
      logic ara;
      logic ev_tog;
      tasl_pkg::tasl_ev_e ev_kind;
      logic [7:0] ev_byte;
      logic pt_s1;
      logic pt_s2;
      logic pt_s3;
      logic [7:0] rdat;
      logic al_s1;
      logic al_s2;
   } tasl_lk_s;

   typedef struct packed {
      logic oe;
      logic drv;
   } tasl_drv_s;

   tasl_ref_s s_r;
   tasl_ref_s s_nxt;
   tasl_lk_s l_r;
   tasl_lk_s l_nxt;
   tasl_drv_s d_r;
   tasl_drv_s d_nxt;
   logic st_tog_r;
   logic fault_now;
   logic done_ok;
   logic ev_now;
   logic soft_now;

   // Channel index from the low three pointer bits, local sits at 7
   function automatic logic [2:0] chan_of(input logic [2:0] a);
      chan_of = (a == 3'h7) ? 3'h0 : a;
   endfunction

   // Register layout to per-channel vector and back
   function automatic logic [6:0] by_chan(input logic [7:0] r);
      by_chan = {r[5:0], r[6]};
   endfunction

   function automatic logic [7:0] to_reg(input logic [6:0] v);
      to_reg = {1'b0, v[0], v[6:1]};
   endfunction

   // Mask bit of one channel, channel 0 is the local sensor
   function automatic logic chan_masked(input logic [7:0] r, input logic [2:0] c);
      logic [6:0] v;
      v = by_chan(r);
      chan_masked = v[c];
   endfunction

   function automatic tasl_ref_s ref_init();
      tasl_ref_s f;
      f = '0;
      f.ptr = tasl_pkg::PTR_RST; // [R14]
      f.cfg1 = tasl_pkg::CFG_RST; // [R15]
      f.cfg2 = tasl_pkg::CFG_RST; // [R19]
      f.cfg3 = tasl_pkg::CFG_RST; // [R20]
      f.alim = tasl_pkg::ALIM_RST;
      f.olim = tasl_pkg::OLIM_RST;
      return f;
   endfunction

   function automatic logic [7:0] rd_byte(input tasl_ref_s r);
      logic [7:0] p;
      p = r.ptr;
      if (p == tasl_pkg::REG_EXT)
         rd_byte = r.ext;
      else if (p == tasl_pkg::REG_MFG)
         rd_byte = MFG_ID;
      else if (p == tasl_pkg::REG_CFG1)
         rd_byte = r.cfg1;
      else if (p == tasl_pkg::REG_CFG2)
         rd_byte = r.cfg2;
      else if (p == tasl_pkg::REG_CFG3)
         rd_byte = r.cfg3;
      else if (p == tasl_pkg::REG_STAT1)
         rd_byte = to_reg(r.st1); // [R21]
      else if (p == tasl_pkg::REG_STAT2)
         rd_byte = to_reg(r.st2 & tasl_pkg::OT_CH);
      else if (p == tasl_pkg::REG_STAT3)
         rd_byte = to_reg(r.st3 & 7'h7e);
      else if (p[3] || p[2:0] == 3'h0)
         rd_byte = 8'h00;
      else if (p[7:4] == tasl_pkg::BANK_TEMP)
         rd_byte = r.temp[chan_of(p[2:0])];
      else if (p[7:4] == tasl_pkg::BANK_ALIM)
         rd_byte = r.alim[chan_of(p[2:0])];
      else if (p[7:4] == tasl_pkg::BANK_OLIM && tasl_pkg::OT_CH[chan_of(p[2:0])])
         rd_byte = r.olim[chan_of(p[2:0])];
      else
         rd_byte = 8'h00;
   endfunction

   // Register side, conversion sequencing and alarms
   always_comb
   begin
      logic [2:0] c;
      logic [7:0] t;
      logic [7:0] b;
      logic [7:0] rb;
      logic standby;
      c = s_r.chan;
      t = conv_data[10:3]; // [R23]
      b = l_r.ev_byte;
      rb = rd_byte(s_r);
      standby = s_r.cfg1[tasl_pkg::CFG1_STOP] | s_r.hw_standby_pin_s2;
      s_nxt = s_r;
      fault_now = 1'b0;
      done_ok = 1'b0;
      soft_now = 1'b0;
      s_nxt.ev_s1 = l_r.ev_tog;
      s_nxt.ev_s2 = s_r.ev_s1;
      s_nxt.ev_s3 = s_r.ev_s2;
      s_nxt.open_s1 = diode_open;
      s_nxt.open_s2 = s_r.open_s1;
      s_nxt.hw_standby_pin_s1 = hw_standby_pin;
      s_nxt.hw_standby_pin_s2 = s_r.hw_standby_pin_s1;
      ev_now = s_r.ev_s2 != s_r.ev_s3;
      // Clears from the link come first so a same-cycle set wins
      if (ev_now)
      begin
         case (l_r.ev_kind)
            tasl_pkg::EV_PTR: s_nxt.ptr = b; // [R14]
            tasl_pkg::EV_WR:
            begin
               if (s_r.ptr == tasl_pkg::REG_CFG1)
               begin
                  soft_now = b[tasl_pkg::CFG1_SOFT]; // [R16]
                  s_nxt.cfg1 = b & tasl_pkg::CFG1_WMASK; // [R15] [R17] [R18]
               end
               else if (s_r.ptr == tasl_pkg::REG_CFG2)
                  s_nxt.cfg2 = b & tasl_pkg::CFG2_WMASK; // [R19]
               else if (s_r.ptr == tasl_pkg::REG_CFG3)
                  s_nxt.cfg3 = b & tasl_pkg::CFG3_WMASK; // [R20]
               else if (s_r.ptr[3] || s_r.ptr[2:0] == 3'h0)
                  s_nxt.ptr = s_r.ptr;
               else if (s_r.ptr[7:4] == tasl_pkg::BANK_ALIM)
                  s_nxt.alim[chan_of(s_r.ptr[2:0])] = b; // [R6]
               else if (s_r.ptr[7:4] == tasl_pkg::BANK_OLIM &&
                        tasl_pkg::OT_CH[chan_of(s_r.ptr[2:0])])
                  s_nxt.olim[chan_of(s_r.ptr[2:0])] = b; // [R6]
            end
            tasl_pkg::EV_RD:
            begin
               if (s_r.ptr == tasl_pkg::REG_STAT1)
               begin
                  s_nxt.st1 = 7'h00; // [R22]
                  s_nxt.alert = 1'b0; // [R8]
               end
               else if (s_r.ptr == tasl_pkg::REG_STAT2)
                  s_nxt.st2 = 7'h00;
               else if (s_r.ptr == tasl_pkg::REG_STAT3)
                  s_nxt.st3 = 7'h00;
            end
            default: s_nxt.alert = 1'b0; // [R8] [R11]
         endcase
      end
      // Alerts play no part here, so conversions run on regardless
      if (standby)
      begin
         s_nxt.req = 1'b0; // [R15]
         s_nxt.fcnt = 16'h0000;
      end
      else if (!s_r.req)
         s_nxt.req = 1'b1; // [R9]
      else
      begin
         fault_now = c != 3'h0 && s_r.open_s2 && s_r.fcnt == 16'(FAULT_CYC - 1); // [R4]
         done_ok = conv_done && !fault_now;
         if (c != 3'h0 && s_r.open_s2)
            s_nxt.fcnt = s_r.fcnt + 16'h0001;
         else
            s_nxt.fcnt = 16'h0000;
         if (fault_now)
         begin
            s_nxt.temp[c] = tasl_pkg::FAULT_TEMP; // [R2] [R3]
            s_nxt.st3[c] = 1'b1;
         end
         else if (done_ok)
         begin
            s_nxt.temp[c] = t;
            if (c == 3'h1)
               s_nxt.ext = {conv_data[2:0], 5'h00}; // [R1]
            if (t > s_r.alim[c])
            begin
               s_nxt.st1[c] = 1'b1; // [R22] [R24]
               if (!chan_masked(s_r.cfg2, c))
                  s_nxt.alert = 1'b1; // [R7] [R19]
            end
            if (tasl_pkg::OT_CH[c])
            begin
               if (t > s_r.olim[c])
               begin
                  s_nxt.ot[c] = 1'b1; // [R13]
                  s_nxt.st2[c] = 1'b1;
               end
               else if ({1'b0, t} + tasl_pkg::OT_HYST < {1'b0, s_r.olim[c]})
                  s_nxt.ot[c] = 1'b0; // [R13]
            end
         end
         if (fault_now || done_ok)
         begin
            s_nxt.fcnt = 16'h0000;
            if (s_r.cfg1[tasl_pkg::CFG1_FAST] && c != 3'h1)
               s_nxt.chan = 3'h1; // [R18]
            else
            begin
               s_nxt.rr = (s_r.rr == 3'h6) ? 3'h0 : s_r.rr + 3'h1; // [R5]
               s_nxt.chan = s_nxt.rr;
            end
         end
      end
      s_nxt.ot_oe = |(s_nxt.ot & ~by_chan(s_nxt.cfg3) & tasl_pkg::OT_CH); // [R20] [R24]
      // Offer the byte at the pointer to the link
      if (rb != s_r.pub_byte)
      begin
         s_nxt.pub_byte = rb;
         s_nxt.pub_tog = ~s_r.pub_tog;
      end
      if (soft_now)
      begin
         s_nxt = ref_init(); // [R16]
         s_nxt.ev_s1 = l_r.ev_tog;
         s_nxt.ev_s2 = s_r.ev_s1;
         s_nxt.ev_s3 = s_r.ev_s2;
         s_nxt.pub_byte = s_r.pub_byte;
         s_nxt.pub_tog = s_r.pub_tog;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         s_r <= ref_init();
      else
         s_r <= s_nxt;
   end

   // Start condition: data falls while the link clock is high
   always_ff @(negedge sda_in or posedge rst)
   begin
      if (rst)
         st_tog_r <= 1'b0;
      else if (scl)
         st_tog_r <= ~st_tog_r;
   end

   // Link receive and transmit sequencing on rising link clock
   always_comb
   begin
      logic [7:0] nb;
      nb = {l_r.sh[6:0], sda_in};
      l_nxt = l_r;
      l_nxt.pt_s1 = s_r.pub_tog;
      l_nxt.pt_s2 = l_r.pt_s1;
      l_nxt.pt_s3 = l_r.pt_s2;
      l_nxt.al_s1 = s_r.alert;
      l_nxt.al_s2 = l_r.al_s1;
      if (l_r.pt_s2 != l_r.pt_s3)
         l_nxt.rdat = s_r.pub_byte;
      if (st_tog_r != l_r.st_seen)
      begin
         l_nxt.st_seen = st_tog_r;
         l_nxt.state = tasl_pkg::LK_ADDR;
         l_nxt.sh = {7'h00, sda_in};
         l_nxt.cnt = 3'h1;
         l_nxt.first = 1'b1;
      end
      else
      begin
         case (l_r.state)
            tasl_pkg::LK_ADDR:
            begin
               l_nxt.sh = nb;
               l_nxt.cnt = l_r.cnt + 3'h1;
               if (l_r.cnt == 3'h7)
               begin
                  l_nxt.rw = nb[0];
                  l_nxt.ara = 1'b0;
                  if (nb[7:1] == SLAVE_ADDR)
                     l_nxt.state = tasl_pkg::LK_ACK;
                  else if (nb[7:1] == tasl_pkg::ARA_ADDR && nb[0] && l_r.al_s2)
                  begin
                     l_nxt.state = tasl_pkg::LK_ACK; // [R10] [R11]
                     l_nxt.ara = 1'b1;
                  end
                  else
                     l_nxt.state = tasl_pkg::LK_IDLE;
               end
            end
            tasl_pkg::LK_ACK:
            begin
               l_nxt.cnt = 3'h0;
               if (l_r.rw)
               begin
                  l_nxt.state = tasl_pkg::LK_TX;
                  l_nxt.sh = l_r.ara ? {SLAVE_ADDR, 1'b0} : l_r.rdat; // [R11]
               end
               else
                  l_nxt.state = tasl_pkg::LK_RX;
            end
            tasl_pkg::LK_RX:
            begin
               l_nxt.sh = nb;
               l_nxt.cnt = l_r.cnt + 3'h1;
               if (l_r.cnt == 3'h7)
               begin
                  l_nxt.ev_byte = nb;
                  l_nxt.ev_kind = l_r.first ? tasl_pkg::EV_PTR : tasl_pkg::EV_WR; // [R14]
                  l_nxt.ev_tog = ~l_r.ev_tog;
                  l_nxt.first = 1'b0;
                  l_nxt.state = tasl_pkg::LK_ACK;
               end
            end
            tasl_pkg::LK_TX:
            begin
               l_nxt.sh = {l_r.sh[6:0], 1'b0};
               l_nxt.cnt = l_r.cnt + 3'h1;
               if (l_r.ara && l_r.sh[7] && !sda_in)
                  l_nxt.state = tasl_pkg::LK_IDLE; // [R12]
               else if (l_r.cnt == 3'h7)
                  l_nxt.state = tasl_pkg::LK_HACK;
            end
            tasl_pkg::LK_HACK:
            begin
               l_nxt.ev_kind = l_r.ara ? tasl_pkg::EV_ARA : tasl_pkg::EV_RD; // [R8]
               l_nxt.ev_tog = ~l_r.ev_tog;
               l_nxt.state = tasl_pkg::LK_IDLE;
            end
            default: l_nxt.state = tasl_pkg::LK_IDLE;
         endcase
      end
   end

   always_ff @(posedge scl or posedge rst)
   begin
      if (rst)
         l_r <= '0;
      else
         l_r <= l_nxt;
   end

   // Data line is changed only while the link clock is low
   always_comb
   begin
      d_nxt.drv = 1'b0;
      d_nxt.oe = l_r.state == tasl_pkg::LK_ACK ||
                 (l_r.state == tasl_pkg::LK_TX && !l_r.sh[7]); // [R11]
   end

   always_ff @(negedge scl or posedge rst)
   begin
      if (rst)
         d_r <= '0;
      else
         d_r <= d_nxt;
   end

   assign sda_out = d_r.drv;
   assign sda_oe = d_r.oe;
   assign conv_chan = s_r.chan;
   assign conv_req = s_r.req;
   assign alert_oe = s_r.alert;
   assign overtemp_out = s_r.ot_oe;
   assign timeout_dis = s_r.cfg1[tasl_pkg::CFG1_TMO]; // [R17]
   assign fast_ch1 = s_r.cfg1[tasl_pkg::CFG1_FAST];
   assign res_cancel = s_r.cfg1[tasl_pkg::CFG1_RCAN]; // [R18]

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_ext_frac;
      done_ok && !soft_now && s_r.chan == 3'h1 |=> s_r.ext == {$past(conv_data[2:0]), 5'h00};
   endproperty
   a_ext_frac: assert property (p_ext_frac) else $error("fraction misplaced"); // [R1]

   property p_fault_ff;
      fault_now && !soft_now |=> s_r.temp[$past(s_r.chan)] == 8'hff && s_r.st3 != 7'h00;
   endproperty
   a_fault_ff: assert property (p_fault_ff) else $error("fault not recorded"); // [R2]

   property p_fault_quiet;
      fault_now && !s_r.alert && !s_r.ot_oe |=> !s_r.alert && !s_r.ot_oe;
   endproperty
   a_fault_quiet: assert property (p_fault_quiet) else $error("fault raised alarm"); // [R3]

   property p_fault_time;
      fault_now |-> s_r.fcnt == 16'(FAULT_CYC - 1) && $past(s_r.open_s2);
   endproperty
   a_fault_time: assert property (p_fault_time) else $error("fault too early"); // [R4]

   property p_fault_adv;
      fault_now && !soft_now |=> s_r.chan != $past(s_r.chan) && s_r.fcnt == 16'h0000;
   endproperty
   a_fault_adv: assert property (p_fault_adv) else $error("no advance"); // [R5]

   property p_alert_set;
      done_ok && !soft_now && conv_data[10:3] > s_r.alim[s_r.chan] &&
         !chan_masked(s_r.cfg2, s_r.chan) |=> s_r.alert;
   endproperty
   a_alert_set: assert property (p_alert_set) else $error("alert missed"); // [R7]

   property p_alert_clr;
      ev_now && l_r.ev_kind == tasl_pkg::EV_ARA && !done_ok |=> !s_r.alert;
   endproperty
   a_alert_clr: assert property (p_alert_clr) else $error("alert not cleared"); // [R8]

   property p_stop;
      s_r.cfg1[tasl_pkg::CFG1_STOP] || s_r.hw_standby_pin_s2 |=> !conv_req;
   endproperty
   a_stop: assert property (p_stop) else $error("converting in standby"); // [R15]

   property p_soft;
      soft_now |=> s_r.cfg1 == 8'h00 && s_r.ptr == 8'h00 && s_r.alim == tasl_pkg::ALIM_RST;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset failed"); // [R16]

   property p_ot_mask;
      overtemp_out |-> (s_r.ot & ~by_chan(s_r.cfg3) & tasl_pkg::OT_CH) != 7'h00;
   endproperty
   a_ot_mask: assert property (p_ot_mask) else $error("masked overtemp"); // [R24]
endmodule

// ===== dv/tasl_host.sv
// Behavioural 2-wire host controller for the alarm logic bench
`timescale 1ns/1ns
module tasl_host #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   // Bus wires
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   int nacks = 0;
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Data moves in the low phase and is taken at the rising edge
   task automatic bit_io(input logic b, output logic s);
      scl = 1'b0;
      #6 sda_low = !b;
      #18 scl = 1'b1;
      s = sda;
      #24;
   endtask
   task automatic start();
      scl = 1'b0;
      #6 sda_low = 1'b0;
      #18 scl = 1'b1;
      #24 sda_low = 1'b1;
      #24;
   endtask
   // Stop, then idle long enough for events to cross
   task automatic stop();
      scl = 1'b0;
      #6 sda_low = 1'b1;
      #18 scl = 1'b1;
      #24 sda_low = 1'b0;
      #700;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ck, output logic [7:0] rx);
      logic a;
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(1'b1, a);
      if (ck && a !== 1'b0)
         nacks++;
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] r;
      start();
      xfer({ADDR, 1'b0}, 1'b1, r);
      xfer(p, 1'b1, r);
      xfer(d, 1'b1, r);
      stop();
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic [7:0] r;
      start();
      xfer({ADDR, 1'b0}, 1'b1, r);
      xfer(p, 1'b1, r);
      #700 start();
      xfer({ADDR, 1'b1}, 1'b1, r);
      xfer(8'hff, 1'b0, d);
      stop();
   endtask
   // Receive byte; zeros in pull are driven low as a rival slave would
   task automatic rcv(input logic [6:0] a, input logic [7:0] pull, output logic [7:0] d);
      logic [7:0] r;
      start();
      xfer({a, 1'b1}, 1'b1, r);
      xfer(pull, 1'b0, d);
      stop();
   endtask
endmodule

// ===== dv/tb_temp_alarm_status_logic.sv
// Self-checking bench for the temperature alarm and status logic
`timescale 1ns/1ns
module tb_temp_alarm_status_logic;
   localparam logic [6:0] SADDR = 7'h2a;
   // Arbitrary identification value
   localparam logic [7:0] MFG = 8'h3c;
   localparam int FCYC = 20;
   localparam logic [7:0] OT_SEQ [5] = '{8'h70, 8'h6b, 8'h6a, 8'h69, 8'h71};
   logic ref_clk = 1'b0;
   logic rst = 1'b0;
   logic conv_done = 1'b0;
   logic [10:0] conv_data = 11'h000;
   logic diode_open = 1'b0;
   logic hw_standby_pin = 1'b0;
   logic scl, h_low, sda_out, sda_oe, conv_req, alert_oe, overtemp_out;
   logic timeout_dis, fast_ch1, res_cancel;
   logic [2:0] conv_chan;
   logic [10:0] tmp [7];
   logic [6:0] open_ch = 7'h00;
   logic fe_run = 1'b1;
   int gap = 0;
   int fail_count = 0;
   int samples_checked = 0;
   wire sda = !(h_low || (sda_oe && !sda_out));

   tasl_top #(.SLAVE_ADDR(SADDR), .MFG_ID(MFG), .FAULT_CYC(FCYC)) uut (
      .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .conv_done(conv_done), .conv_data(conv_data),
      .diode_open(diode_open), .conv_chan(conv_chan), .conv_req(conv_req),
      .hw_standby_pin(hw_standby_pin), .alert_oe(alert_oe), .overtemp_out(overtemp_out),
      .timeout_dis(timeout_dis), .fast_ch1(fast_ch1), .res_cancel(res_cancel));
   tasl_host #(.ADDR(SADDR)) u_host (.scl(scl), .sda_low(h_low), .sda(sda));

   initial
   begin
      forever #50 ref_clk = !ref_clk;
   end

   // Front end answers each conversion of a channel not in open_ch after a random few cycles
   always @(posedge ref_clk)
   begin
      #5;
      diode_open = open_ch[conv_chan];
      gap = (gap > 0) ? gap - 1 : 0;
      conv_done = 1'b0;
      if (conv_req === 1'b1 && fe_run && gap == 0 && !open_ch[conv_chan]
          && ($urandom & 32'h3) == 0)
      begin
         conv_data = tmp[conv_chan];
         conv_done = 1'b1;
         gap = 3;
      end
   end

   function automatic logic ot_next(input logic prev, input logic [7:0] t,
                                    input logic [7:0] lim);
      if (t > lim)
         return 1'b1;
      return (({1'b0, t} + 9'h004) < {1'b0, lim}) ? 1'b0 : prev;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(p, d);
      chk(d, exp);
   endtask
   task automatic sweep();
      repeat (15) @(posedge conv_done);
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic lim1(input logic [7:0] a, input logic [7:0] rv, input logic w);
      logic [7:0] v;
      rchk(a, rv);
      if (w)
      begin
         v = 8'($urandom);
         u_host.wr(a, v);
         rchk(a, v);
      end
   endtask
   task automatic lims(input logic w);
      for (int c = 0; c < 7; c++)
      begin
         lim1((c == 0) ? 8'h17 : 8'h10 + 8'(c), tasl_pkg::ALIM_RST[c], w);
         if (tasl_pkg::OT_CH[c])
            lim1(8'h20 + 8'(c), tasl_pkg::OLIM_RST[c], w);
      end
   endtask
   task automatic final_report();
      $display("checks=%0d errors=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      #3000000;
      fail_count++;
      final_report();
   end

   initial
   begin
      logic [7:0] d, v;
      logic [2:0] f;
      logic ot;
      int n;
      void'($urandom(16576));
      // A rising reset edge clears the link flops before the link clock runs
      #1 rst = 1'b1;
      for (int c = 0; c < 7; c++)
         tmp[c] = {8'h30, 3'h0};
      repeat (10) @(posedge ref_clk);
      #5 rst = 1'b0;
      #1000;
      rchk(tasl_pkg::REG_CFG1, 8'h00);
      rchk(tasl_pkg::REG_CFG2, 8'h00);
      rchk(tasl_pkg::REG_CFG3, 8'h00);
      rchk(tasl_pkg::REG_MFG, MFG);
      u_host.wr(8'h30, 8'hff);
      u_host.rcv(SADDR, 8'hff, d);
      chk(d, 8'h00);
      lims(1'b1);
      u_host.wr(tasl_pkg::REG_CFG2, 8'h7f);
      u_host.wr(tasl_pkg::REG_CFG1, 8'h40);
      lims(1'b0);
      rchk(tasl_pkg::REG_CFG2, 8'h00);
      rchk(tasl_pkg::REG_CFG1, 8'h00);
      v = 8'($urandom) & 8'h38;
      for (int k = 0; k < 2; k++)
      begin
         u_host.wr(tasl_pkg::REG_CFG1, v);
         rchk(tasl_pkg::REG_CFG1, v);
         chk({5'h0, timeout_dis, fast_ch1, res_cancel}, {5'h0, v[5:3]});
         v = v ^ 8'h38;
      end
      u_host.wr(tasl_pkg::REG_CFG1, 8'h80);
      chk({7'h0, conv_req}, 8'h00);
      u_host.wr(tasl_pkg::REG_CFG1, 8'h00);
      chk({7'h0, conv_req}, 8'h01);
      @(posedge ref_clk);
      #5 hw_standby_pin = 1'b1;
      repeat (4) @(posedge ref_clk);
      chk({7'h0, conv_req}, 8'h00);
      #5 hw_standby_pin = 1'b0;
      // Conversion of channel 1 with a random fraction
      f = 3'($urandom);
      tmp[1] = {8'h30, f};
      sweep();
      rchk(8'h01, 8'h30);
      u_host.rd(tasl_pkg::REG_EXT, d);
      chk(d & 8'he0, {f, 5'h00});
      // Alert raised, cleared by status read, raised again
      tmp[3] = {8'h70, 3'h0};
      sweep();
      chk({7'h0, alert_oe}, 8'h01);
      sweep();
      @(posedge ref_clk);
      fe_run = 1'b0;
      repeat (10) @(posedge ref_clk);
      rchk(tasl_pkg::REG_STAT1, 8'h04);
      chk({7'h0, alert_oe}, 8'h00);
      rchk(tasl_pkg::REG_STAT1, 8'h00);
      fe_run = 1'b1;
      sweep();
      chk({7'h0, alert_oe}, 8'h01);
      fe_run = 1'b0;
      repeat (10) @(posedge ref_clk);
      u_host.rcv(tasl_pkg::ARA_ADDR, 8'h40, d);
      chk(d, 8'h40);
      chk({7'h0, alert_oe}, 8'h01);
      u_host.rcv(tasl_pkg::ARA_ADDR, 8'hff, d);
      chk(d, {SADDR, 1'b0});
      chk({7'h0, alert_oe}, 8'h00);
      u_host.wr(tasl_pkg::REG_CFG2, 8'h04);
      fe_run = 1'b1;
      sweep();
      chk({7'h0, alert_oe}, 8'h00);
      rchk(tasl_pkg::REG_STAT1, 8'h04);
      tmp[3] = {8'h30, 3'h0};
      u_host.wr(tasl_pkg::REG_CFG2, 8'h00);
      // Overtemperature with hysteresis on channel 1
      ot = 1'b0;
      foreach (OT_SEQ[i])
      begin
         tmp[1] = {OT_SEQ[i], 3'h0};
         sweep();
         ot = ot_next(ot, OT_SEQ[i], 8'h6e);
         chk({7'h0, overtemp_out}, {7'h0, ot});
      end
      rchk(tasl_pkg::REG_STAT2, 8'h01);
      u_host.wr(tasl_pkg::REG_CFG3, 8'h01);
      sweep();
      chk({7'h0, overtemp_out}, 8'h00);
      tmp[1] = {8'h30, 3'h0};
      u_host.wr(tasl_pkg::REG_CFG3, 8'h00);
      sweep();
      u_host.rd(tasl_pkg::REG_STAT1, d);
      // Open diode on channel 5
      open_ch[5] = 1'b1;
      wait (conv_chan == 3'd4);
      wait (conv_chan == 3'd5);
      n = 0;
      while (conv_chan == 3'd5 && n < 200)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk({7'h0, n >= FCYC && n <= FCYC + 8}, 8'h01);
      sweep();
      rchk(8'h05, 8'hff);
      rchk(tasl_pkg::REG_STAT3, 8'h10);
      chk({6'h0, alert_oe, overtemp_out}, 8'h00);
      chk(8'(u_host.nacks), 8'h00);
      final_report();
   end
endmodule
